// ### logic/asp_pkg.sv
package asp_pkg;
	// Packet geometry
	localparam int          PKT_BITS      = 64;
	localparam int          CNT_W         = 7;
	localparam logic [6:0]  PKT_LEN       = 7'h40;
	// Control word fields (packet bit positions)
	localparam int          ANCHOR_BIT    = 63;
	localparam int          CLEAR_BIT     = 62;
	localparam int          REGACC_BIT    = 61;
	localparam int          RKIND_HI      = 60;
	localparam int          RKIND_LO      = 58;
	localparam int          WKIND_HI      = 57;
	localparam int          WKIND_LO      = 56;
	localparam int          ADDR_HI       = 47;
	localparam int          ADDR_LO       = 32;
	localparam int          DATA_HI       = 31;
	localparam int          DATA_LO       = 16;
	localparam logic [2:0]  RKIND_POS     = 3'h4;
	localparam logic [1:0]  WKIND_REG     = 2'h3;
	localparam logic [1:0]  WKIND_NULL    = 2'h0;
	// Status positions in the response
	localparam int          ST_FATAL      = 5;
	localparam int          ST_ACTIVE     = 4;
	localparam int          ST_NEWPOS     = 3;
	localparam int          ST_FRAME      = 1;
	localparam int          ST_LINKREQ    = 0;
	// Register offsets
	localparam logic [15:0] A_DGAIN       = 16'h4030;
	localparam logic [15:0] A_AGAIN       = 16'h4032;
	localparam logic [15:0] A_PHTRIM      = 16'h4034;
	localparam logic [15:0] A_UNUM_LO     = 16'h403c;
	localparam logic [15:0] A_UNUM_HI     = 16'h403e;
	localparam logic [15:0] A_AMP         = 16'h4048;
	localparam logic [15:0] A_SOFS_RES    = 16'h404e;
	localparam logic [15:0] A_COFS_RES    = 16'h4050;
	localparam logic [15:0] A_BAL_RES     = 16'h4052;
	localparam logic [15:0] A_PH_RES      = 16'h4054;
	localparam logic [15:0] A_IPH_RES     = 16'h4058;
	localparam logic [15:0] A_SOFS_PK     = 16'h405e;
	localparam logic [15:0] A_COFS_PK     = 16'h4060;
	localparam logic [15:0] A_BAL_PK      = 16'h4062;
	localparam logic [15:0] A_PH_PK       = 16'h4064;
	localparam logic [15:0] A_IPH_PK      = 16'h4066;
	localparam logic [15:0] A_TEMP        = 16'h4068;
	localparam logic [15:0] A_PROFILE     = 16'h4094;
	localparam logic [15:0] A_USN0        = 16'h4096;
	localparam logic [15:0] A_USN1        = 16'h4098;
	localparam logic [15:0] A_ULAB0       = 16'h409a;
	localparam logic [15:0] A_ULAB1       = 16'h409c;
	localparam logic [15:0] A_ULAB2       = 16'h409e;
	localparam logic [15:0] A_UMAKER      = 16'h40a0;
	localparam logic [15:0] A_PART        = 16'he000;
	localparam logic [15:0] A_PARTREV     = 16'he002;
	localparam logic [15:0] RW_RESET      = 16'h0000;
	localparam logic [63:0] RESP_RESET    = 64'h0;
	// Writable register count
	localparam int          N_RW          = 15;
endpackage : asp_pkg

// ### logic/asp_spi_port.sv
`timescale 1ns/1ns
module asp_spi_port
	import asp_pkg::*;
#(
	parameter logic [15:0] PART_CODE = 16'h0a5a, // Arbitrary value
	parameter logic [15:0] PART_REV  = 16'h0101  // Arbitrary value
) (
	input  wire logic        I_SYS_CLK,            // System clock
	input  wire logic        I_RSTN,               // Sync reset, low active
	input  wire logic        I_SCLK,               // Serial clock pin
	input  wire logic        I_PORT_SELECT_LOW,    // Select pin, low active
	input  wire logic        I_SDI,                // Serial data in
	output logic             O_SDO,                // Serial data out
	input  wire logic [31:0] I_REV_COUNT,          // Revolution count
	input  wire logic [25:0] I_ANGLE,              // Angle
	input  wire logic        I_FATAL,              // Fatal fault level
	input  wire logic        I_STAT_ACTIVE,        // Status condition level
	input  wire logic        I_NEWPOS_EVT,         // New position pulse
	input  wire logic        I_FRAME_EVT,          // New link frame pulse
	input  wire logic        I_LINK_REQ,           // Link register request
	input  wire logic [31:0] I_UNIT_NUMBER,        // Factory unit number
	input  wire logic [15:0] I_AMP,                // Vector amplitude
	input  wire logic [15:0] I_SOFS_RES,           // Sine offset residue
	input  wire logic [15:0] I_COFS_RES,           // Cosine offset residue
	input  wire logic [15:0] I_BAL_RES,            // Balance residue
	input  wire logic [15:0] I_PH_RES,             // Phase residue
	input  wire logic [15:0] I_IPH_RES,            // Interp phase residue
	input  wire logic [15:0] I_TEMP,               // Die temperature
	output logic             O_ANCHOR,             // Anchor request pulse
	output logic [15:0]      O_DIGITAL_GAIN_TRIM,  // Trim out
	output logic [15:0]      O_ANALOG_GAIN_TRIM,   // Trim out
	output logic [15:0]      O_PHASE_TRIM,         // Trim out
	output logic [15:0]      O_LINK_PROFILE_CODE,  // Profile out
	output logic             O_CMD_DONE            // Command executed pulse
);

	typedef struct packed {
		logic [2:0]       sclk_s;
		logic [2:0]       sel_s;
		logic [1:0]       sdi_s;
		logic [63:0]      shin;
		logic [63:0]      shout;
		logic [63:0]      pend;
		logic [6:0]       cnt;
		logic             sdo;
		logic             newpos;
		logic             frame;
		logic             clr_arm;
		logic             anchor;
		logic             done;
		logic [N_RW-1:0][15:0] rw;
	} asp_state_t;

	asp_state_t st_reg;
	asp_state_t st_next;

	logic        sclk_rise;
	logic        sclk_fall;
	logic        sel_fall;
	logic        sel_rise;
	logic        sel_low;
	logic [15:0] rd_data;
	logic [15:0] cmd_addr;
	logic [63:0] rsp;

	// Timing outline: data passes two flip-flops, clock and select three; edges come from
	// the second and third stages. A bit therefore lands about three system
	// cycles after its serial clock edge. That is why the link clock must
	// stay well below a quarter of the system clock. The response is
	// assembled once, at select fall, and then only shifted. Values that
	// move during a frame therefore never tear a word in half.
	// A frame with fewer than 64 clocks is dropped at select rise, and
	// nothing that it shifted in is used.

	// Edge detection on second and third stages only
	assign sclk_rise = st_reg.sclk_s[1] & ~st_reg.sclk_s[2];
	assign sclk_fall = ~st_reg.sclk_s[1] & st_reg.sclk_s[2];
	assign sel_fall  = ~st_reg.sel_s[1] & st_reg.sel_s[2];
	assign sel_rise  = st_reg.sel_s[1] & ~st_reg.sel_s[2];
	assign sel_low   = ~st_reg.sel_s[1];
	assign cmd_addr  = st_reg.shin[ADDR_HI:ADDR_LO];

	// Register read mux; unknown addresses answer zero
	always_comb begin
		case (cmd_addr)
			A_DGAIN:    rd_data = st_reg.rw[0];
			A_AGAIN:    rd_data = st_reg.rw[1];
			A_PHTRIM:   rd_data = st_reg.rw[2];
			A_SOFS_PK:  rd_data = st_reg.rw[3];
			A_COFS_PK:  rd_data = st_reg.rw[4];
			A_BAL_PK:   rd_data = st_reg.rw[5];
			A_PH_PK:    rd_data = st_reg.rw[6];
			A_IPH_PK:   rd_data = st_reg.rw[7];
			A_PROFILE:  rd_data = st_reg.rw[8];
			A_USN0:     rd_data = st_reg.rw[9];
			A_USN1:     rd_data = st_reg.rw[10];
			A_ULAB0:    rd_data = st_reg.rw[11];
			A_ULAB1:    rd_data = st_reg.rw[12];
			A_ULAB2:    rd_data = st_reg.rw[13];
			A_UMAKER:   rd_data = st_reg.rw[14];
			A_UNUM_LO:  rd_data = I_UNIT_NUMBER[15:0];
			A_UNUM_HI:  rd_data = I_UNIT_NUMBER[31:16];
			A_AMP:      rd_data = I_AMP;
			A_SOFS_RES: rd_data = I_SOFS_RES;
			A_COFS_RES: rd_data = I_COFS_RES;
			A_BAL_RES:  rd_data = I_BAL_RES;
			A_PH_RES:   rd_data = I_PH_RES;
			A_IPH_RES:  rd_data = I_IPH_RES;
			A_TEMP:     rd_data = I_TEMP;
			A_PART:     rd_data = PART_CODE;
			A_PARTREV:  rd_data = PART_REV;
			default:    rd_data = 16'h0000;
		endcase
	end

	// Response snapshot for select fall. It is built from zero each time,
	// so register data only shows when the previous command asked for it.
	always_comb begin
		rsp = RESP_RESET;
		if (st_reg.pend[2]) begin
			// Position read: count and angle as they stand now
			rsp[63:32] = I_REV_COUNT;
			rsp[31:6]  = I_ANGLE;
		end
		if (st_reg.pend[0]) begin
			// Register word replaces the upper count half
			rsp[63:48] = st_reg.pend[63:48];
		end
		// Status bits 5:0; bit 2 always reads zero
		rsp[ST_FATAL]   = I_FATAL;
		rsp[ST_ACTIVE]  = I_STAT_ACTIVE;
		rsp[ST_NEWPOS]  = st_reg.newpos;
		rsp[ST_FRAME]   = st_reg.frame;
		rsp[ST_LINKREQ] = I_LINK_REQ;
	end

	// Main next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.sclk_s = {st_reg.sclk_s[1:0], I_SCLK};
		st_next.sel_s  = {st_reg.sel_s[1:0], I_PORT_SELECT_LOW};
		st_next.sdi_s  = {st_reg.sdi_s[0], I_SDI};
		st_next.anchor = 1'b0;
		st_next.done   = 1'b0;

		// Sticky events: a set in the clear cycle survives
		if (I_NEWPOS_EVT)
			st_next.newpos = 1'b1;
		if (I_FRAME_EVT)
			st_next.frame = 1'b1;

		if (sel_fall) begin
			// Load the snapshot into the outgoing frame
			st_next.shout = rsp;
			st_next.sdo   = rsp[PKT_BITS-1];
			st_next.cnt   = '0;
			if (st_reg.clr_arm) begin
				st_next.newpos  = I_NEWPOS_EVT;
				st_next.frame   = I_FRAME_EVT;
				st_next.clr_arm = 1'b0;
			end
		end else if (sel_low) begin
			// Shift in on rise, out on fall
			if (sclk_rise && st_reg.cnt != PKT_LEN) begin
				st_next.shin = {st_reg.shin[62:0], st_reg.sdi_s[1]};
				st_next.cnt  = st_reg.cnt + 7'h01;
			end
			if (sclk_fall) begin
				st_next.shout = {st_reg.shout[62:0], 1'b0};
				st_next.sdo   = st_reg.shout[62];
			end
		end

		if (sel_rise && st_reg.cnt == PKT_LEN) begin
			st_next.done   = 1'b1;
			st_next.anchor = st_reg.shin[ANCHOR_BIT];
			if (st_reg.shin[CLEAR_BIT])
				st_next.clr_arm = 1'b1;
			// Pending descriptor: reg data, read-kind flags
			st_next.pend = RESP_RESET;
			st_next.pend[2] = (st_reg.shin[RKIND_HI:RKIND_LO] == RKIND_POS);
			st_next.pend[0] = st_reg.shin[REGACC_BIT];
			st_next.pend[63:48] = rd_data;
			if (st_reg.shin[WKIND_HI:WKIND_LO] == WKIND_REG) begin
				for (int i = 0; i < N_RW; i++) begin
					if (rd_data == st_reg.rw[i] && cmd_addr != A_UNUM_LO)
						st_next.rw[i] = st_next.rw[i];
				end
				case (cmd_addr)
					A_DGAIN:   st_next.rw[0]  = st_reg.shin[DATA_HI:DATA_LO];
					A_AGAIN:   st_next.rw[1]  = st_reg.shin[DATA_HI:DATA_LO];
					A_PHTRIM:  st_next.rw[2]  = st_reg.shin[DATA_HI:DATA_LO];
					A_SOFS_PK: st_next.rw[3]  = st_reg.shin[DATA_HI:DATA_LO];
					A_COFS_PK: st_next.rw[4]  = st_reg.shin[DATA_HI:DATA_LO];
					A_BAL_PK:  st_next.rw[5]  = st_reg.shin[DATA_HI:DATA_LO];
					A_PH_PK:   st_next.rw[6]  = st_reg.shin[DATA_HI:DATA_LO];
					A_IPH_PK:  st_next.rw[7]  = st_reg.shin[DATA_HI:DATA_LO];
					A_PROFILE: st_next.rw[8]  = st_reg.shin[DATA_HI:DATA_LO];
					A_USN0:    st_next.rw[9]  = st_reg.shin[DATA_HI:DATA_LO];
					A_USN1:    st_next.rw[10] = st_reg.shin[DATA_HI:DATA_LO];
					A_ULAB0:   st_next.rw[11] = st_reg.shin[DATA_HI:DATA_LO];
					A_ULAB1:   st_next.rw[12] = st_reg.shin[DATA_HI:DATA_LO];
					A_ULAB2:   st_next.rw[13] = st_reg.shin[DATA_HI:DATA_LO];
					A_UMAKER:  st_next.rw[14] = st_reg.shin[DATA_HI:DATA_LO];
					default:   st_next.rw[0]  = st_next.rw[0];
				endcase
			end
			// Null write: bits 31:0 only shifted, never used
		end
		// Short frame: nothing taken, pending answer kept
		if (sel_rise && st_reg.cnt != PKT_LEN)
			st_next.cnt = '0;

		if (!I_RSTN) begin
			st_next = '0;
			st_next.sclk_s = 3'h0;
			st_next.sel_s  = 3'h7;
		end
	end

	// State register
	always_ff @(posedge I_SYS_CLK) begin
		st_reg <= st_next;
	end

	assign O_SDO               = st_reg.sdo;
	assign O_ANCHOR            = st_reg.anchor;
	assign O_CMD_DONE          = st_reg.done;
	assign O_DIGITAL_GAIN_TRIM = st_reg.rw[0];
	assign O_ANALOG_GAIN_TRIM  = st_reg.rw[1];
	assign O_PHASE_TRIM        = st_reg.rw[2];
	assign O_LINK_PROFILE_CODE = st_reg.rw[8];

endmodule : asp_spi_port

// ### tb/asp_spi_port_checker.sv
`timescale 1ns/1ns
module asp_spi_port_checker (
	input wire logic        I_SYS_CLK,           // Clock
	input wire logic        I_RSTN,              // Reset, low active
	input wire logic        I_SCLK,              // Serial clock
	input wire logic        I_PORT_SELECT_LOW,   // Select
	input wire logic        O_SDO,               // Serial out
	input wire logic        O_ANCHOR,            // Anchor pulse
	input wire logic        O_CMD_DONE,          // Done pulse
	input wire logic [15:0] O_DIGITAL_GAIN_TRIM, // Trim
	input wire logic [15:0] O_ANALOG_GAIN_TRIM,  // Trim
	input wire logic [15:0] O_PHASE_TRIM,        // Trim
	input wire logic [15:0] O_LINK_PROFILE_CODE  // Profile
);
	// One domain, quiet while in reset
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RSTN);
	property p_anc_done; O_ANCHOR |-> O_CMD_DONE; endproperty
	a_anc_done: assert property (p_anc_done) else $error("anchor outside execution");
	property p_anc_pulse; O_ANCHOR |=> !O_ANCHOR; endproperty
	a_anc_pulse: assert property (p_anc_pulse) else $error("anchor too long");
	property p_done_gap; O_CMD_DONE |=> !O_CMD_DONE [*5]; endproperty
	a_done_gap: assert property (p_done_gap) else $error("double execution");
	property p_done_hi; O_CMD_DONE |-> I_PORT_SELECT_LOW && $past(I_PORT_SELECT_LOW, 2); endproperty
	a_done_hi: assert property (p_done_hi) else $error("execution before select rise");
	property p_no_exec_low; !I_PORT_SELECT_LOW [*3] |-> !O_CMD_DONE; endproperty
	a_no_exec_low: assert property (p_no_exec_low) else $error("execution inside frame");
	// Trims move only around an execution
	property p_trim_exec;
		$changed({O_DIGITAL_GAIN_TRIM, O_ANALOG_GAIN_TRIM, O_PHASE_TRIM, O_LINK_PROFILE_CODE})
		|-> (##[0:2] O_CMD_DONE) or ($past(O_CMD_DONE) || $past(O_CMD_DONE, 2));
	endproperty
	a_trim_exec: assert property (p_trim_exec) else $error("trim changed without command");
	property p_sdo_low; $changed(O_SDO) |-> !I_SCLK; endproperty
	a_sdo_low: assert property (p_sdo_low) else $error("output moved while clock high");
	property p_sdo_hold; I_SCLK [*5] |=> $stable(O_SDO); endproperty
	a_sdo_hold: assert property (p_sdo_hold) else $error("output unstable at sampling");
	c_anchor: cover property (O_ANCHOR);
	c_done: cover property (O_CMD_DONE);
	c_trim: cover property ($changed(O_PHASE_TRIM));
endmodule : asp_spi_port_checker

bind asp_spi_port asp_spi_port_checker i_asp_spi_port_checker (.*);

// ### tb/asp_host_model.sv
`timescale 1ns/1ns
module asp_host_model (
	output logic      o_sclk,       // Serial clock
	output logic      o_select_low, // Select, low active
	output logic      o_sdi,        // Command bit
	input  wire logic i_sdo         // Response bit
);
	// Idle clock low, select high while reset releases
	initial begin
		o_sclk <= 1'b0;
		o_select_low <= 1'b1;
		o_sdi <= 1'b0;
	end
	// Whole packets only unless a discard test asks for fewer clocks
	task automatic xfer(input logic [63:0] c, input int n, output logic [63:0] r);
		r = 64'h0;
		o_select_low <= 1'b0;
		for (int i = 0; i < n; i++) begin
			o_sdi <= c[63-i];
			#62 o_sclk <= 1'b1;
			r = {r[62:0], i_sdo};
			#63 o_sclk <= 1'b0;
		end
		#62 o_select_low <= 1'b1;
		o_sdi <= ~o_sdi; // Released line must not look held
		#100;
	endtask : xfer
endmodule : asp_host_model

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	import asp_pkg::*;
	localparam logic [15:0] PCODE = 16'h1234; // Arbitrary value
	localparam logic [15:0] PREV  = 16'h0042; // Arbitrary value
	logic        clk, rstn, sclk, sel_low, sdi, sdo, fat, act, npe, fre, lr, anc, done;
	logic [31:0] rev, unum;
	logic [25:0] ang;
	logic [15:0] amp, res, tmp, dg, ag, pt, pc, rdv, a;
	logic [63:0] pcmd, r, e;
	logic [2:0]  f;
	bit   [15:0] mem [65536];
	bit          np, fr;
	int          n_errors, checked, nd, na, ea;
	logic [15:0] tbl [12] = '{A_DGAIN, A_AGAIN, A_PHTRIM, A_PROFILE, A_PH_PK, A_UMAKER,
		A_UNUM_HI, A_AMP, A_TEMP, A_PART, A_PH_RES, 16'h4002};
	asp_spi_port #(.PART_CODE(PCODE), .PART_REV(PREV)) i_asp_spi_port (
		.I_SYS_CLK(clk), .I_RSTN(rstn), .I_SCLK(sclk), .I_PORT_SELECT_LOW(sel_low),
		.I_SDI(sdi), .O_SDO(sdo), .I_REV_COUNT(rev), .I_ANGLE(ang), .I_FATAL(fat),
		.I_STAT_ACTIVE(act), .I_NEWPOS_EVT(npe), .I_FRAME_EVT(fre), .I_LINK_REQ(lr),
		.I_UNIT_NUMBER(unum), .I_AMP(amp), .I_SOFS_RES(res), .I_COFS_RES(res),
		.I_BAL_RES(res), .I_PH_RES(res), .I_IPH_RES(res), .I_TEMP(tmp), .O_ANCHOR(anc),
		.O_DIGITAL_GAIN_TRIM(dg), .O_ANALOG_GAIN_TRIM(ag), .O_PHASE_TRIM(pt),
		.O_LINK_PROFILE_CODE(pc), .O_CMD_DONE(done));
	asp_host_model i_asp_host_model (.o_sclk(sclk), .o_select_low(sel_low), .o_sdi(sdi),
		.i_sdo(sdo));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Pulse counters feed the execution and anchor checks
	always @(posedge clk) begin
		if (done === 1'b1) nd++;
		if (anc === 1'b1) na++;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [63:0] mk(input logic [2:0] fl, input logic [1:0] w,
		input logic [15:0] ad, input logic [15:0] d);
		return {fl, RKIND_POS, w, 8'h00, ad, d, 16'h0000};
	endfunction : mk
	// Register file as seen from the port; unmapped reads give zero
	function automatic logic [15:0] rd(input logic [15:0] ad);
		case (ad)
			A_UNUM_HI: return unum[31:16];
			A_AMP: return amp;
			A_TEMP: return tmp;
			A_PART: return PCODE;
			A_PH_RES: return res;
			default: return mem[ad];
		endcase
	endfunction : rd
	// One transfer; the response belongs to the previous command
	task automatic step(input logic [63:0] c, input int n, input bit cmp);
		int nd0;
		nd0 = nd;
		// Status and position stand still during the frame; read them after
		i_asp_host_model.xfer(c, n, r);
		e = 64'h0;
		if (pcmd[RKIND_HI:RKIND_LO] == RKIND_POS) e[63:6] = {rev, ang};
		if (pcmd[REGACC_BIT]) e[63:48] = rdv;
		e[5:0] = {fat, act, np, 1'b0, fr, lr};
		if (cmp) chk(r, e);
		if (n == 64) begin
			if (pcmd[CLEAR_BIT]) {np, fr} = 2'b00;
			for (int k = 0; k < 30 && nd == nd0; k++) @(posedge clk);
			repeat (2) @(posedge clk);
			chk(nd, nd0 + 1);
			if (c[WKIND_HI:WKIND_LO] == WKIND_REG && c[47:32] inside {A_DGAIN, A_AGAIN,
				A_PHTRIM, A_PROFILE, A_PH_PK, A_UMAKER}) mem[c[47:32]] = c[31:16];
			rdv = rd(c[ADDR_HI:ADDR_LO]);
			pcmd = c;
			ea += c[ANCHOR_BIT];
			chk(na, ea);
			chk({dg, ag, pt, pc}, {mem[A_DGAIN], mem[A_AGAIN], mem[A_PHTRIM], mem[A_PROFILE]});
			@(posedge clk);
			rev <= $urandom;
			ang <= 26'($urandom);
			{fat, act, lr} <= 3'($urandom);
		end else begin
			repeat (30) @(posedge clk);
			chk(nd, nd0);
		end
	endtask : step
	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#500000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(51490));
		{rstn, npe, fre, pcmd, rdv} = '0;
		{rev, unum, amp, res, tmp} = {$urandom, $urandom, $urandom, $urandom};
		ang = 26'($urandom);
		{fat, act, lr} = 3'($urandom);
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		step(mk(3'h0, WKIND_REG, A_DGAIN, 16'($urandom)), 64, 0);
		foreach (tbl[i]) begin
			step(mk(3'h0, WKIND_REG, tbl[i], 16'($urandom)), 64, 1);
			step(mk(3'h1, WKIND_NULL, tbl[i], 16'h0000), 64, 1);
		end
		// Events, then anchor with flag clear
		@(posedge clk);
		{npe, fre} <= 2'b11;
		@(posedge clk);
		{npe, fre} <= 2'b00;
		{np, fr} = 2'b11;
		step(mk(3'h6, WKIND_NULL, 16'h0000, 16'h0000), 64, 1);
		step(64'h0, 64, 1);
		step(64'h0, 64, 1);
		step(mk(3'h0, WKIND_NULL, 16'($urandom), 16'($urandom)), 64, 1);
		step(mk(3'h0, WKIND_REG, A_AGAIN, 16'h5a5a), 20, 0);
		step(64'h0, 64, 1);
		step({16'h0000, A_DGAIN, 32'h0000_0000}, 64, 1);
		repeat (6) begin
			f = 3'($urandom) & 3'h5;
			a = tbl[$urandom_range(11)];
			step(mk(f, f[0] ? WKIND_NULL : WKIND_REG, a, 16'($urandom)), 64, 1);
		end
		step(64'h0, 64, 1);
		tally_and_finish();
	end
endmodule : testbench
